// file: design/ffc_defs.svh
// Register offsets, field positions, reset values and cache geometry of the fetch cache.
`ifndef FFC_DEFS_SVH
`define FFC_DEFS_SVH

// Register byte offsets on the plain register port.
`define FFC_OFS_FETCH_CTRL 8'h04
`define FFC_OFS_STATUS 8'h1C
`define FFC_OFS_FLAGS 8'h30
`define FFC_OFS_FLAG_CLR 8'h38
`define FFC_OFS_HITS 8'h48
`define FFC_OFS_MISSES 8'h4C
`define FFC_OFS_COMMAND 8'h74

// Field positions of fetch_control_reg.
`define FFC_CTRL_MODE_LSB 0
`define FFC_CTRL_MODE_MSB 2
`define FFC_CTRL_CACHE_DIS 3
`define FFC_CTRL_AUTO_INV_DIS 4
`define FFC_CTRL_IRQ_CACHE_DIS 5
`define FFC_CTRL_W 6
`define FFC_CTRL_RESET 6'h01

// Field positions of command_reg (write one to act).
`define FFC_CMD_INVALIDATE 0
`define FFC_CMD_CNT_START 1
`define FFC_CMD_CNT_STOP 2
`define FFC_CMD_BANK_SWAP 3

// Field positions of status_reg.
`define FFC_STAT_BANK_SWAPPED 0
`define FFC_STAT_SWAP_ENABLED 1
`define FFC_STAT_CNT_RUNNING 2
`define FFC_STAT_FETCH_BUSY 3

// Field positions of the flag register and its clear register.
`define FFC_FLAG_HIT_OVF 0
`define FFC_FLAG_MISS_OVF 1
`define FFC_FLAG_LV_WRITE 2
`define FFC_FLAG_W 3

// Performance counter width and reset value.
`define FFC_CNT_W 16
`define FFC_CNT_RESET 16'h0000

// Cache geometry: 32 lines of 4 words, direct mapped over a 1 MB flash window.
`define FFC_WORDS 128
`define FFC_LINES 32
`define FFC_IDX_W 7
`define FFC_LINE_W 5
`define FFC_TAG_W 11
`define FFC_FLASH_HI 12'h000
`define FFC_BANK_BIT 19

`endif

// file: design/ffc_pkg.sv
// Types shared by the fetch cache modules.
package ffc_pkg;

   typedef enum logic [2:0] {
      MODE_ZERO_WAIT = 3'h0,
      MODE_ONE_WAIT = 3'h1,
      MODE_ZERO_SUPPRESS = 3'h2,
      MODE_ONE_SUPPRESS = 3'h3,
      MODE_TWO_SUPPRESS = 3'h4
   } ffc_mode_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_WAIT = 2'b10
   } ffc_state_type;

endpackage

// file: design/ffc_mem.sv
// Cache data store with registered read data and a load path for words from flash.
`timescale 1ns/1ps
`include "ffc_defs.svh"

module ffc_mem (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Lookup read
   input wire logic rd_en,
   input wire logic [`FFC_IDX_W-1:0] rd_addr,
   // Fill write
   input wire logic wr_en,
   input wire logic [`FFC_IDX_W-1:0] wr_addr,
   // Word returned from flash, shown on the read register
   input wire logic ld_en,
   input wire logic [31:0] ld_data,
   // Read data
   output logic [31:0] rd_data
);

   logic [31:0] store [0:`FFC_WORDS-1];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         store[wr_addr] <= ld_data;
      end
   end

   // A word from flash goes straight to the read register so that hit and miss answers share one
   // flip-flop on the way to the processor.
   always_ff @(posedge clk) begin
      if (srst) begin
         rd_data <= 32'h00000000;
      end else if (ld_en) begin
         rd_data <= ld_data;
      end else if (rd_en) begin
         rd_data <= store[rd_addr];
      end
   end

endmodule

// file: design/ffc_top.sv
// Flash instruction fetch path: fetch cache, performance counters, write guard and bank swap.
`timescale 1ns/1ps
`include "ffc_defs.svh"

module ffc_top (
   // Clock and reset
   input wire logic MCLK,
   input wire logic SRST,
   // Register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [31:0] REG_RDATA,
   // Processor instruction fetch
   input wire logic FETCH_REQ,
   input wire logic [31:0] FETCH_ADDR,
   input wire logic FETCH_IRQ_CTX,
   input wire logic FETCH_SPEC,
   output logic FETCH_READY,
   output logic FETCH_VALID,
   output logic FETCH_CANCEL,
   output logic FETCH_ERR,
   output logic [31:0] FETCH_DATA,
   // Memory system read
   output logic MEM_REQ,
   output logic [31:0] MEM_ADDR,
   output logic [1:0] MEM_WAIT,
   input wire logic MEM_ACK,
   input wire logic MEM_ERR,
   input wire logic [31:0] MEM_RDATA,
   // Flash write and erase guard
   input wire logic FLASH_CMD_REQ,
   output logic FLASH_CMD_GO,
   input wire logic LOW_VOLTAGE,
   // Energy mode entry and configuration lock word
   input wire logic SLEEP_ENTER,
   input wire logic LOCK_SWAP_DISABLE
);

   // True for the on-chip flash window.
   function automatic logic in_flash(input logic [31:0] addr);
      in_flash = (addr[31:20] == `FFC_FLASH_HI);
   endfunction

   // True when the read mode cancels speculative branch target fetches.
   function automatic logic suppress_mode(input logic [2:0] mode);
      unique case (ffc_pkg::ffc_mode_type'(mode))
         ffc_pkg::MODE_ZERO_SUPPRESS,
         ffc_pkg::MODE_ONE_SUPPRESS,
         ffc_pkg::MODE_TWO_SUPPRESS: suppress_mode = 1'b1;
         ffc_pkg::MODE_ZERO_WAIT,
         ffc_pkg::MODE_ONE_WAIT: suppress_mode = 1'b0;
         default: suppress_mode = 1'b0;
      endcase
   endfunction

   // Flash wait states for a read mode; unknown codes fall back to the slowest timing.
   function automatic logic [1:0] wait_states(input logic [2:0] mode);
      unique case (ffc_pkg::ffc_mode_type'(mode))
         ffc_pkg::MODE_ZERO_WAIT,
         ffc_pkg::MODE_ZERO_SUPPRESS: wait_states = 2'h0;
         ffc_pkg::MODE_ONE_WAIT,
         ffc_pkg::MODE_ONE_SUPPRESS: wait_states = 2'h1;
         ffc_pkg::MODE_TWO_SUPPRESS: wait_states = 2'h2;
         default: wait_states = 2'h2;
      endcase
   endfunction

   // Configuration and state.
   logic [`FFC_CTRL_W-1:0] ctrl;
   logic [`FFC_CNT_W-1:0] hit_cnt;
   logic [`FFC_CNT_W-1:0] miss_cnt;
   logic cnt_run;
   logic [`FFC_FLAG_W-1:0] flags;
   logic bank_swapped;
   logic swap_enabled;
   logic lv_meta;
   logic lv_sync;
   ffc_pkg::ffc_state_type state;
   ffc_pkg::ffc_state_type next_state;

   // Cache bookkeeping.
   logic [`FFC_WORDS-1:0] word_valid;
   logic [`FFC_TAG_W-1:0] line_tag [0:`FFC_LINES-1];
   logic [`FFC_IDX_W-1:0] pend_idx;
   logic [`FFC_TAG_W-1:0] pend_tag;
   logic pend_alloc;

   // Decoded strobes and fetch decisions.
   logic ctrl_wr;
   logic cmd_wr;
   logic clr_wr;
   logic cache_dis;
   logic auto_inv_dis;
   logic irq_cache_dis;
   logic accept;
   logic cancel;
   logic cacheable;
   logic no_alloc;
   logic hit;
   logic take_hit;
   logic to_mem;
   logic mem_done;
   logic count_hit;
   logic count_miss;
   logic cmd_start;
   logic cmd_stop;
   logic invalidate;
   logic do_swap;
   logic [`FFC_IDX_W-1:0] fetch_idx;
   logic [`FFC_LINE_W-1:0] fetch_line;
   logic [`FFC_LINE_W-1:0] pend_line;
   logic [`FFC_TAG_W-1:0] fetch_tag;
   logic [`FFC_FLAG_W-1:0] flag_set;
   logic [31:0] next_rdata;

   assign ctrl_wr = REG_WR && (REG_ADDR == `FFC_OFS_FETCH_CTRL);
   assign cmd_wr = REG_WR && (REG_ADDR == `FFC_OFS_COMMAND);
   assign clr_wr = REG_WR && (REG_ADDR == `FFC_OFS_FLAG_CLR);
   assign cache_dis = ctrl[`FFC_CTRL_CACHE_DIS];
   assign auto_inv_dis = ctrl[`FFC_CTRL_AUTO_INV_DIS];
   assign irq_cache_dis = ctrl[`FFC_CTRL_IRQ_CACHE_DIS];
   assign cmd_start = cmd_wr && REG_WDATA[`FFC_CMD_CNT_START];
   assign cmd_stop = cmd_wr && REG_WDATA[`FFC_CMD_CNT_STOP];
   assign do_swap = cmd_wr && REG_WDATA[`FFC_CMD_BANK_SWAP] && swap_enabled;

   assign fetch_idx = FETCH_ADDR[`FFC_IDX_W+1:2];
   assign fetch_line = FETCH_ADDR[`FFC_IDX_W+1:4];
   assign fetch_tag = FETCH_ADDR[`FFC_IDX_W+`FFC_TAG_W+1:`FFC_IDX_W+2];
   assign pend_line = pend_idx[`FFC_IDX_W-1:2];

   assign accept = FETCH_REQ && (state == ffc_pkg::ST_IDLE);
   // In the three suppress read modes a speculative branch target fetch is answered with a cancel and never reaches flash.
   assign cancel = FETCH_SPEC && suppress_mode(ctrl[`FFC_CTRL_MODE_MSB:`FFC_CTRL_MODE_LSB]);
   assign cacheable = in_flash(FETCH_ADDR) && !cache_dis;
   // With the interrupt option set, interrupt fetches still look up but leave no trace.
   assign no_alloc = FETCH_IRQ_CTX && irq_cache_dis;
   assign hit = word_valid[fetch_idx] && (line_tag[fetch_line] == fetch_tag);
   assign take_hit = accept && !cancel && cacheable && hit;
   assign to_mem = accept && !cancel && !(cacheable && hit);
   assign mem_done = (state == ffc_pkg::ST_WAIT) && MEM_REQ && MEM_ACK;
   assign count_hit = take_hit && !no_alloc && cnt_run;
   assign count_miss = to_mem && cacheable && !no_alloc && cnt_run;

   // Every source of invalidation; a bus fault is deliberately not one of them.
   assign invalidate = (cmd_wr && REG_WDATA[`FFC_CMD_INVALIDATE])
      || SLEEP_ENTER
      || (FLASH_CMD_REQ && !lv_sync && !auto_inv_dis)
      || do_swap;

   assign flag_set[`FFC_FLAG_HIT_OVF] = count_hit && (hit_cnt == {`FFC_CNT_W{1'b1}});
   assign flag_set[`FFC_FLAG_MISS_OVF] = count_miss && (miss_cnt == {`FFC_CNT_W{1'b1}});
   assign flag_set[`FFC_FLAG_LV_WRITE] = FLASH_CMD_REQ && lv_sync;

   ffc_mem u_mem (
      .clk(MCLK),
      .srst(SRST),
      .rd_en(take_hit),
      .rd_addr(fetch_idx),
      .wr_en(mem_done && pend_alloc && !invalidate),
      .wr_addr(pend_idx),
      .ld_en(mem_done),
      .ld_data(MEM_RDATA),
      .rd_data(FETCH_DATA)
   );

   // Low-voltage state comes from the supply monitor and is synchronised first.
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         lv_meta <= 1'b0;
         lv_sync <= 1'b0;
      end else begin
         lv_meta <= LOW_VOLTAGE;
         lv_sync <= lv_meta;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         ctrl <= `FFC_CTRL_RESET;
      end else if (ctrl_wr) begin
         ctrl <= REG_WDATA[`FFC_CTRL_W-1:0];
      end
   end

   // The lock word bit is held through reset, so its last value before release decides.
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         swap_enabled <= !LOCK_SWAP_DISABLE;
         bank_swapped <= 1'b0;
      end else if (do_swap) begin
         bank_swapped <= !bank_swapped;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         FLASH_CMD_GO <= 1'b0;
      end else begin
         FLASH_CMD_GO <= FLASH_CMD_REQ && !lv_sync;
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         cnt_run <= 1'b0;
         hit_cnt <= `FFC_CNT_RESET;
         miss_cnt <= `FFC_CNT_RESET;
      end else if (cmd_start) begin
         cnt_run <= 1'b1;
         hit_cnt <= `FFC_CNT_RESET;
         miss_cnt <= `FFC_CNT_RESET;
      end else if (cmd_stop) begin
         cnt_run <= 1'b0;
      end else begin
         if (count_hit) begin
            hit_cnt <= hit_cnt + 1'b1;
         end
         if (count_miss) begin
            miss_cnt <= miss_cnt + 1'b1;
         end
      end
   end

   // A new event wins over a clear arriving in the same cycle.
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         flags <= {`FFC_FLAG_W{1'b0}};
      end else begin
         flags <= (flags & ~(clr_wr ? REG_WDATA[`FFC_FLAG_W-1:0] : {`FFC_FLAG_W{1'b0}}))
            | flag_set;
      end
   end

   always_comb begin
      next_state = state;
      unique case (state)
         ffc_pkg::ST_IDLE: begin
            if (to_mem) begin
               next_state = ffc_pkg::ST_WAIT;
            end
         end
         ffc_pkg::ST_WAIT: begin
            if (mem_done) begin
               next_state = ffc_pkg::ST_IDLE;
            end
         end
         default: next_state = ffc_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         state <= ffc_pkg::ST_IDLE;
         FETCH_READY <= 1'b0;
      end else begin
         state <= next_state;
         FETCH_READY <= (next_state == ffc_pkg::ST_IDLE);
      end
   end

   // An invalidate while a miss is outstanding drops the allocation, since the word may be stale.
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         pend_idx <= {`FFC_IDX_W{1'b0}};
         pend_tag <= {`FFC_TAG_W{1'b0}};
         pend_alloc <= 1'b0;
      end else if (to_mem) begin
         pend_idx <= fetch_idx;
         pend_tag <= fetch_tag;
         pend_alloc <= cacheable && !no_alloc && !invalidate;
      end else if (invalidate) begin
         pend_alloc <= 1'b0;
      end
   end

   // Words fill one at a time; a new tag on a line drops the other words of that line.
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         word_valid <= {`FFC_WORDS{1'b0}};
      end else if (invalidate) begin
         word_valid <= {`FFC_WORDS{1'b0}};
      end else if (mem_done && pend_alloc) begin
         if (line_tag[pend_line] != pend_tag) begin
            for (int w = 0; w < 4; w++) begin
               word_valid[{pend_line, w[1:0]}] <= 1'b0;
            end
         end
         word_valid[pend_idx] <= 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (mem_done && pend_alloc && !invalidate) begin
         line_tag[pend_line] <= pend_tag;
      end
   end

   // The flash address has the two instances exchanged while the bank swap is active.
   always_ff @(posedge MCLK) begin
      if (SRST) begin
         MEM_REQ <= 1'b0;
         MEM_ADDR <= 32'h00000000;
         MEM_WAIT <= 2'h1;
      end else begin
         MEM_WAIT <= wait_states(ctrl[`FFC_CTRL_MODE_MSB:`FFC_CTRL_MODE_LSB]);
         if (to_mem) begin
            MEM_REQ <= 1'b1;
            MEM_ADDR <= FETCH_ADDR;
            if (in_flash(FETCH_ADDR)) begin
               MEM_ADDR[`FFC_BANK_BIT] <= FETCH_ADDR[`FFC_BANK_BIT] ^ bank_swapped;
            end
         end else if (mem_done) begin
            MEM_REQ <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         FETCH_VALID <= 1'b0;
         FETCH_CANCEL <= 1'b0;
         FETCH_ERR <= 1'b0;
      end else begin
         FETCH_VALID <= take_hit || (accept && cancel) || mem_done;
         FETCH_CANCEL <= accept && cancel;
         FETCH_ERR <= mem_done && MEM_ERR;
      end
   end

   always_comb begin
      next_rdata = 32'h00000000;
      unique case (REG_ADDR)
         `FFC_OFS_FETCH_CTRL: next_rdata[`FFC_CTRL_W-1:0] = ctrl;
         `FFC_OFS_STATUS: begin
            next_rdata[`FFC_STAT_BANK_SWAPPED] = bank_swapped;
            next_rdata[`FFC_STAT_SWAP_ENABLED] = swap_enabled;
            next_rdata[`FFC_STAT_CNT_RUNNING] = cnt_run;
            next_rdata[`FFC_STAT_FETCH_BUSY] = (state == ffc_pkg::ST_WAIT);
         end
         `FFC_OFS_FLAGS: next_rdata[`FFC_FLAG_W-1:0] = flags;
         `FFC_OFS_HITS: next_rdata[`FFC_CNT_W-1:0] = hit_cnt;
         `FFC_OFS_MISSES: next_rdata[`FFC_CNT_W-1:0] = miss_cnt;
         default: next_rdata = 32'h00000000;
      endcase
   end

   always_ff @(posedge MCLK) begin
      if (SRST) begin
         REG_RDATA <= 32'h00000000;
      end else begin
         REG_RDATA <= REG_RD ? next_rdata : 32'h00000000;
      end
   end

endmodule

// file: verif/ffc_mem_model.sv
// Memory system responder standing behind the fetch cache.
`timescale 1ns/1ps
module ffc_mem_model (
   // Clock and reset
   input wire logic clk,
   input wire logic srst,
   // Read request from the cache
   input wire logic req,
   input wire logic [31:0] addr,
   // Answer
   output logic ack,
   output logic err,
   output logic [31:0] rdata,
   // Test controls
   input wire logic [3:0] dly,
   input wire logic fault
);
   logic [3:0] cnt;
   logic served;

   // Outside an answer the data lines toggle, so nothing stale can pass for a word.
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt <= 4'h0;
         served <= 1'b0;
         ack <= 1'b0;
         err <= 1'b0;
         rdata <= 32'h0;
      end else if (req && !served && cnt == dly) begin
         ack <= 1'b1;
         served <= 1'b1;
         err <= fault;
         rdata <= addr ^ 32'h5A5A0000;
      end else begin
         ack <= 1'b0;
         err <= ~err;
         rdata <= ~rdata;
         cnt <= req ? cnt + 4'h1 : 4'h0;
         served <= served && req;
      end
   end
endmodule

// file: verif/ffc_top_monitor.sv
// Concurrent checks on the fetch cache ports.
`timescale 1ns/1ps
module ffc_top_monitor (
   // Clock and reset
   input logic MCLK,
   input logic SRST,
   // Fetch side
   input logic FETCH_REQ,
   input logic [31:0] FETCH_ADDR,
   input logic FETCH_SPEC,
   input logic FETCH_READY,
   input logic FETCH_VALID,
   input logic FETCH_CANCEL,
   input logic FETCH_ERR,
   input logic [31:0] FETCH_DATA,
   // Memory side
   input logic MEM_REQ,
   input logic [31:0] MEM_ADDR,
   input logic MEM_ACK,
   input logic MEM_ERR,
   input logic [31:0] MEM_RDATA,
   // Write guard
   input logic FLASH_CMD_REQ,
   input logic FLASH_CMD_GO,
   input logic LOW_VOLTAGE
);
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (SRST);
   a_mem_held: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR))
      else $error("memory request left early");
   a_ack_answer: assert property (MEM_REQ && MEM_ACK |=> FETCH_VALID
      && FETCH_DATA == $past(MEM_RDATA) && FETCH_ERR == $past(MEM_ERR))
      else $error("memory answer not passed on");
   a_take_answer: assert property (FETCH_REQ && FETCH_READY |=> FETCH_VALID || MEM_REQ)
      else $error("taken fetch got no answer");
   a_refuse_busy: assert property (MEM_REQ |-> !FETCH_READY)
      else $error("ready during outstanding miss");
   a_cancel_clean: assert property (FETCH_CANCEL |-> FETCH_VALID && !MEM_REQ
      && !FETCH_ERR && $past(FETCH_SPEC))
      else $error("bad cancel");
   a_bypass_addr: assert property ($rose(MEM_REQ) && MEM_ADDR[31:20] != 12'h000
      |-> MEM_ADDR == $past(FETCH_ADDR))
      else $error("bypass address changed");
   a_lv_block: assert property (LOW_VOLTAGE [*4] ##0 FLASH_CMD_REQ |=> !FLASH_CMD_GO)
      else $error("write passed at low voltage");
   a_cmd_pass: assert property (!LOW_VOLTAGE [*4] ##0 FLASH_CMD_REQ |=> FLASH_CMD_GO)
      else $error("write lost at normal voltage");
   a_go_cause: assert property (FLASH_CMD_GO |-> $past(FLASH_CMD_REQ))
      else $error("write issued without command");
   c_cancel: cover property (FETCH_CANCEL);
   c_fault: cover property (MEM_ACK && MEM_ERR);
   c_lv_cmd: cover property (FLASH_CMD_REQ && LOW_VOLTAGE);
endmodule

bind ffc_top ffc_top_monitor i_mon (.MCLK(MCLK), .SRST(SRST), .FETCH_REQ(FETCH_REQ),
   .FETCH_ADDR(FETCH_ADDR), .FETCH_SPEC(FETCH_SPEC), .FETCH_READY(FETCH_READY),
   .FETCH_VALID(FETCH_VALID), .FETCH_CANCEL(FETCH_CANCEL), .FETCH_ERR(FETCH_ERR),
   .FETCH_DATA(FETCH_DATA), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR), .MEM_ACK(MEM_ACK),
   .MEM_ERR(MEM_ERR), .MEM_RDATA(MEM_RDATA), .FLASH_CMD_REQ(FLASH_CMD_REQ),
   .FLASH_CMD_GO(FLASH_CMD_GO), .LOW_VOLTAGE(LOW_VOLTAGE));

// file: verif/tb.sv
// Self-checking bench for the flash fetch cache.
`timescale 1ns/1ps
`include "ffc_defs.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   logic MCLK, SRST, REG_WR, REG_RD, FETCH_REQ, FETCH_IRQ_CTX, FETCH_SPEC, FETCH_READY;
   logic FETCH_VALID, FETCH_CANCEL, FETCH_ERR, MEM_REQ, MEM_ACK, MEM_ERR, FLASH_CMD_REQ;
   logic FLASH_CMD_GO, LOW_VOLTAGE, SLEEP_ENTER, LOCK_SWAP_DISABLE, fault, bank;
   logic [7:0] REG_ADDR;
   logic [31:0] REG_WDATA, REG_RDATA, FETCH_ADDR, FETCH_DATA, MEM_ADDR, MEM_RDATA;
   logic [1:0] MEM_WAIT, exp_wait;
   logic [3:0] dly;
   logic [1:0] wt [5] = '{2'h0, 2'h1, 2'h0, 2'h1, 2'h2};
   int num_errors = 0;
   int check_count = 0;
   localparam logic [31:0] F = 32'h00001000;
   localparam logic [31:0] B = 32'h00001100;
   localparam logic [31:0] R = 32'h20000040;

   ffc_top i_dut (.MCLK(MCLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FETCH_REQ(FETCH_REQ),
      .FETCH_ADDR(FETCH_ADDR), .FETCH_IRQ_CTX(FETCH_IRQ_CTX), .FETCH_SPEC(FETCH_SPEC),
      .FETCH_READY(FETCH_READY), .FETCH_VALID(FETCH_VALID), .FETCH_CANCEL(FETCH_CANCEL),
      .FETCH_ERR(FETCH_ERR), .FETCH_DATA(FETCH_DATA), .MEM_REQ(MEM_REQ), .MEM_ADDR(MEM_ADDR),
      .MEM_WAIT(MEM_WAIT), .MEM_ACK(MEM_ACK), .MEM_ERR(MEM_ERR), .MEM_RDATA(MEM_RDATA),
      .FLASH_CMD_REQ(FLASH_CMD_REQ), .FLASH_CMD_GO(FLASH_CMD_GO), .LOW_VOLTAGE(LOW_VOLTAGE),
      .SLEEP_ENTER(SLEEP_ENTER), .LOCK_SWAP_DISABLE(LOCK_SWAP_DISABLE));
   ffc_mem_model i_mem (.clk(MCLK), .srst(SRST), .req(MEM_REQ), .addr(MEM_ADDR),
      .ack(MEM_ACK), .err(MEM_ERR), .rdata(MEM_RDATA), .dly(dly), .fault(fault));

   initial begin
      MCLK = 1'b0;
      forever #20 MCLK = ~MCLK;
   end

   task automatic end_sim;
      $display("checks=%0d errors=%0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic rst(input logic lock);
      SRST <= 1'b1;
      LOCK_SWAP_DISABLE <= lock;
      repeat (20) @(posedge MCLK);
      SRST <= 1'b0;
      repeat (2) @(posedge MCLK);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      REG_ADDR <= a;
      REG_WDATA <= d;
      REG_WR <= 1'b1;
      @(posedge MCLK);
      REG_WR <= 1'b0;
      @(posedge MCLK);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      REG_ADDR <= a;
      REG_RD <= 1'b1;
      @(posedge MCLK);
      REG_RD <= 1'b0;
      @(negedge MCLK);
      `CHK(REG_RDATA, e)
      @(posedge MCLK);
   endtask

   // The memory flag is sampled every cycle, since a bypass and a miss look alike here.
   task automatic fetch(input logic [31:0] a, input logic irq, input logic spec, input logic m);
      logic seen;
      int n;
      logic [31:0] pa;
      seen = 1'b0;
      n = 0;
      // With the banks swapped, flash addresses reach the memory with the instance bit flipped.
      pa = a ^ {12'h000, bank && (a[31:20] == 12'h000), 19'h00000};
      FETCH_ADDR <= a;
      FETCH_IRQ_CTX <= irq;
      FETCH_SPEC <= spec;
      FETCH_REQ <= 1'b1;
      @(posedge MCLK);
      FETCH_REQ <= 1'b0;
      @(negedge MCLK);
      while (FETCH_VALID !== 1'b1 && n < 40) begin
         if (MEM_REQ === 1'b1) begin
            seen = 1'b1;
            `CHK(MEM_WAIT, exp_wait)
            `CHK(MEM_ADDR, pa)
         end
         n++;
         @(negedge MCLK);
      end
      `CHK(FETCH_VALID, 1'b1)
      `CHK(seen, m)
      `CHK(FETCH_CANCEL, spec)
      `CHK(FETCH_ERR, m & fault)
      if (!spec) `CHK(FETCH_DATA, pa ^ 32'h5A5A0000)
      if (!m) `CHK(n == 0, 1'b1)
      @(posedge MCLK);
   endtask

   task automatic fcmd(input logic go);
      FLASH_CMD_REQ <= 1'b1;
      @(posedge MCLK);
      FLASH_CMD_REQ <= 1'b0;
      @(negedge MCLK);
      `CHK(FLASH_CMD_GO, go)
      @(posedge MCLK);
   endtask

   initial begin
      {SRST, REG_WR, REG_RD, FETCH_REQ, FETCH_IRQ_CTX, FETCH_SPEC} = 6'h20;
      {FLASH_CMD_REQ, LOW_VOLTAGE, SLEEP_ENTER, LOCK_SWAP_DISABLE, fault} = 5'h00;
      {REG_ADDR, REG_WDATA, FETCH_ADDR, dly, exp_wait, bank} = 0;
      rst(1'b0);
      rd(`FFC_OFS_FETCH_CTRL, 32'h1);
      rd(`FFC_OFS_STATUS, 32'h2);
      exp_wait = 2'h1;
      wr(`FFC_OFS_COMMAND, 32'h2);
      fetch(F, 1'b0, 1'b0, 1'b1);
      fetch(F, 1'b0, 1'b0, 1'b0);
      fetch(F + 32'h4, 1'b0, 1'b0, 1'b1);
      fetch(R, 1'b0, 1'b0, 1'b1);
      fetch(R, 1'b0, 1'b0, 1'b1);
      rd(`FFC_OFS_HITS, 32'h1);
      rd(`FFC_OFS_MISSES, 32'h2);
      dly <= 4'h5;
      wr(`FFC_OFS_FETCH_CTRL, 32'h21);
      fetch(B, 1'b1, 1'b0, 1'b1);
      fetch(B, 1'b1, 1'b0, 1'b1);
      fetch(F, 1'b1, 1'b0, 1'b0);
      rd(`FFC_OFS_HITS, 32'h1);
      wr(`FFC_OFS_FETCH_CTRL, 32'h1);
      fetch(B, 1'b1, 1'b0, 1'b1);
      fetch(B, 1'b1, 1'b0, 1'b0);
      wr(`FFC_OFS_COMMAND, 32'h4);
      fetch(F, 1'b0, 1'b0, 1'b0);
      rd(`FFC_OFS_HITS, 32'h2);
      rd(`FFC_OFS_MISSES, 32'h3);
      wr(`FFC_OFS_COMMAND, 32'h1);
      fetch(F, 1'b0, 1'b0, 1'b1);
      fcmd(1'b1);
      fetch(F, 1'b0, 1'b0, 1'b1);
      wr(`FFC_OFS_FETCH_CTRL, 32'h11);
      fcmd(1'b1);
      fetch(F, 1'b0, 1'b0, 1'b0);
      wr(`FFC_OFS_COMMAND, 32'h1);
      fetch(F, 1'b0, 1'b0, 1'b1);
      SLEEP_ENTER <= 1'b1;
      @(posedge MCLK);
      SLEEP_ENTER <= 1'b0;
      @(posedge MCLK);
      fetch(F, 1'b0, 1'b0, 1'b1);
      wr(`FFC_OFS_FETCH_CTRL, 32'h1);
      LOW_VOLTAGE <= 1'b1;
      repeat (4) @(posedge MCLK);
      fcmd(1'b0);
      fetch(F, 1'b0, 1'b0, 1'b0);
      rd(`FFC_OFS_FLAGS, 32'h4);
      LOW_VOLTAGE <= 1'b0;
      wr(`FFC_OFS_FLAG_CLR, 32'h4);
      rd(`FFC_OFS_FLAGS, 32'h0);
      wr(`FFC_OFS_FETCH_CTRL, 32'h9);
      fetch(F, 1'b0, 1'b0, 1'b1);
      fetch(F, 1'b0, 1'b0, 1'b1);
      dly <= 4'h0;
      // The bench clock is 25 MHz, at which every read mode is a legal choice.
      for (int i = 0; i < 5; i++) begin
         wr(`FFC_OFS_FETCH_CTRL, i);
         exp_wait = wt[i];
         fetch(R, 1'b0, 1'b0, 1'b1);
         if (i > 1) fetch(B, 1'b0, 1'b1, 1'b0);
      end
      wr(`FFC_OFS_FETCH_CTRL, 32'h1);
      exp_wait = 2'h1;
      fault <= 1'b1;
      wr(`FFC_OFS_COMMAND, 32'h1);
      fetch(F, 1'b0, 1'b0, 1'b1);
      fault <= 1'b0;
      fetch(F, 1'b0, 1'b0, 1'b0);
      wr(`FFC_OFS_COMMAND, 32'h2);
      FETCH_REQ <= 1'b1;
      repeat (65536) @(posedge MCLK);
      FETCH_REQ <= 1'b0;
      repeat (3) @(posedge MCLK);
      rd(`FFC_OFS_HITS, 32'h0);
      rd(`FFC_OFS_FLAGS, 32'h1);
      wr(`FFC_OFS_FLAG_CLR, 32'h1);
      rd(`FFC_OFS_FLAGS, 32'h0);
      // The swap is only issued while no flash fetch is outstanding, as from boot code.
      wr(`FFC_OFS_COMMAND, 32'h8);
      bank = 1'b1;
      rd(`FFC_OFS_STATUS, 32'h7);
      fetch(F, 1'b0, 1'b0, 1'b1);
      rst(1'b1);
      bank = 1'b0;
      rd(`FFC_OFS_STATUS, 32'h0);
      wr(`FFC_OFS_COMMAND, 32'h8);
      rd(`FFC_OFS_STATUS, 32'h0);
      fetch(F, 1'b0, 1'b0, 1'b1);
      end_sim;
   end

   // The longest stretch is the counter wrap, about 65,600 cycles.
   initial begin
      #2900000;
      num_errors++;
      end_sim;
   end
endmodule
